// >>> core/dual_clock_flagged_fifo.sv
// Flagged first-in first-out buffer with programmable near-full and near-empty thresholds.
//
// What this block does
// - Full init reset zeroes pointers and output.
// - Full init reset captures mode, defaults, method.
// - Pointer reset zeroes pointers, keeps settings and offsets.
// - Replay restarts reads from location zero.
// - Shared pin: mode at reset, serial data after.
// - Enabled write stores data or offset.
// - Enabled read fetches data or offset.
// - Output enable decides read bus drive.
// - Serial loading only while load gate asserted.
// - Access select at reset picks defaults, method.
// - Access select redirects writes and reads to offsets.
// - Standard mode shared output reports full.
// - Fall-through shared output reports space available.
// - Standard mode shared output reports empty.
// - Fall-through shared output reports output valid.
// - Near-full high when free exceeds m.
// - Near-empty low when count at or below n.
// - Half level flag in both modes.
// - Both data buses are 18 bits.
// - Memory holds 8192 or 16384 words.
// - Fall-through shows first word without read.
// - Serial shift needs gate and access select.
// - Parallel load needs write enable and select.
`timescale 1ns/10ps
`include "flagged_fifo_cfg.svh"

module dual_clock_flagged_fifo #(
  parameter int WIDTH    = `FF_WORD_WIDTH,
  parameter int DEPTH    = `FF_DEPTH_SMALL,
  parameter int IN_DEPTH = `FF_INGRESS_DEPTH
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst_n,
  input  wire logic             i_full_init_reset_n,
  input  wire logic             i_pointer_only_reset_n,
  input  wire logic             i_replay_request_n,
  input  wire logic             i_mode_or_serial_pin,
  input  wire logic             i_serial_load_gate_n,
  input  wire logic             i_offset_access_select_n,
  input  wire logic             i_write_enable_n,
  input  wire logic [WIDTH-1:0] i_write_data_bus,
  input  wire logic             i_read_enable_n,
  input  wire logic             i_output_enable_n,
  output logic      [WIDTH-1:0] o_read_data_bus,
  output logic                  o_read_data_oe,
  output logic                  o_full_or_space_n,
  output logic                  o_empty_or_valid_n,
  output logic                  o_near_full_flag_n,
  output logic                  o_near_empty_flag_n,
  output logic                  o_half_level_flag_n
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam int OW = AW;

  // ==========================================================================
  // State
  flagged_fifo_pkg::latency_mode_t mode_q;
  flagged_fifo_pkg::latency_mode_t mode_d;
  flagged_fifo_pkg::prog_method_t  method_q;
  flagged_fifo_pkg::prog_method_t  method_d;
  logic [OW-1:0]    empty_ofs_q;
  logic [OW-1:0]    empty_ofs_d;
  logic [OW-1:0]    full_ofs_q;
  logic [OW-1:0]    full_ofs_d;
  logic             wr_ofs_sel_q;
  logic             wr_ofs_sel_d;
  logic             rd_ofs_sel_q;
  logic             rd_ofs_sel_d;
  logic [AW-1:0]    wptr_q;
  logic [AW-1:0]    wptr_d;
  logic [AW-1:0]    rptr_q;
  logic [AW-1:0]    rptr_d;
  logic [CW-1:0]    count_q;
  logic [CW-1:0]    count_d;
  logic [WIDTH-1:0] out_q;
  logic [WIDTH-1:0] out_d;
  logic             out_valid_q;
  logic             out_valid_d;
  logic [WIDTH-1:0] mem_q [DEPTH];

  // ==========================================================================
  // Decoded controls
  logic             init;
  logic             prst;
  logic             replay;
  logic             ld;
  logic             wen;
  logic             ren;
  logic             serial_load_gate;
  logic             fall;
  logic             ram_full;
  logic             ram_empty;
  logic             drain;
  logic             pop;
  logic             in_ready;
  logic             skid_valid;
  logic [WIDTH-1:0] skid_data;
  logic [CW-1:0]    level;
  logic [CW-1:0]    free_cnt;
  logic [2*OW-1:0]  shift_next;

  assign init      = !i_full_init_reset_n;
  assign prst      = !i_pointer_only_reset_n;
  assign replay    = !i_replay_request_n;
  assign ld        = !i_offset_access_select_n;
  assign wen       = !i_write_enable_n;
  assign ren       = !i_read_enable_n;
  assign serial_load_gate       = !i_serial_load_gate_n;
  assign fall      = (mode_q == flagged_fifo_pkg::FALL_THROUGH_MODE);
  assign ram_full  = (count_q == CW'(DEPTH));
  assign ram_empty = (count_q == '0);
  assign drain     = skid_valid && !ram_full && !init && !prst && !replay;
  // Offset bits enter at the top; after 2*OW shifts the first bit lands in the empty offset LSB.
  assign shift_next = {i_mode_or_serial_pin, full_ofs_q, empty_ofs_q[OW-1:1]};

  // A read in standard mode, or a refill of the output stage in fall-through mode.
  always_comb begin
    pop = 1'b0;
    if (!init && !prst && !replay && !ram_empty) begin
      if (fall) begin
        pop = !out_valid_q || (ren && !ld);
      end else begin
        pop = ren && !ld;
      end
    end
  end

  // ==========================================================================
  // Ingress buffer: writes land here and drain into the main store while it has room.
  ingress_fifo #(
    .WIDTH (WIDTH),
    .DEPTH (IN_DEPTH)
  ) u_ingress (
    .i_clk_sys   (i_clk_sys),
    .i_rst_n     (i_rst_n),
    .i_flush     (init || prst),
    .i_in_valid  (wen && !ld && !init && !prst),
    .o_in_ready  (in_ready),
    .i_in_data   (i_write_data_bus),
    .o_out_valid (skid_valid),
    .i_out_ready (!ram_full && !init && !prst && !replay),
    .o_out_data  (skid_data)
  );

  // ==========================================================================
  // Settings and offsets
  always_comb begin
    mode_d       = mode_q;
    method_d     = method_q;
    empty_ofs_d  = empty_ofs_q;
    full_ofs_d   = full_ofs_q;
    wr_ofs_sel_d = wr_ofs_sel_q;
    if (init) begin
      mode_d       = i_mode_or_serial_pin ? flagged_fifo_pkg::FALL_THROUGH_MODE
                                          : flagged_fifo_pkg::STANDARD_LATENCY_MODE;
      method_d     = ld ? flagged_fifo_pkg::PROG_PARALLEL : flagged_fifo_pkg::PROG_SERIAL;
      empty_ofs_d  = ld ? OW'(`FF_OFFSET_DEFAULT_NEAR) : OW'(`FF_OFFSET_DEFAULT_FAR);
      full_ofs_d   = ld ? OW'(`FF_OFFSET_DEFAULT_NEAR) : OW'(`FF_OFFSET_DEFAULT_FAR);
      wr_ofs_sel_d = 1'b0;
    end else if (prst) begin
      wr_ofs_sel_d = 1'b0;
    end else if (method_q == flagged_fifo_pkg::PROG_SERIAL) begin
      if (serial_load_gate && ld) begin
        {full_ofs_d, empty_ofs_d} = shift_next;
      end
    end else if (wen && ld) begin
      if (wr_ofs_sel_q) begin
        full_ofs_d = i_write_data_bus[OW-1:0];
      end else begin
        empty_ofs_d = i_write_data_bus[OW-1:0];
      end
      wr_ofs_sel_d = !wr_ofs_sel_q;
    end
  end

  // ==========================================================================
  // Pointers, level and output register
  always_comb begin
    wptr_d       = wptr_q;
    rptr_d       = rptr_q;
    count_d      = count_q;
    out_d        = out_q;
    out_valid_d  = out_valid_q;
    rd_ofs_sel_d = rd_ofs_sel_q;
    if (init || prst) begin
      wptr_d       = '0;
      rptr_d       = '0;
      count_d      = '0;
      out_d        = '0;
      out_valid_d  = 1'b0;
      rd_ofs_sel_d = 1'b0;
    end else if (replay) begin
      // Only exact while fewer than DEPTH words were written since the last reset.
      rptr_d      = '0;
      count_d     = {1'b0, wptr_q};
      out_valid_d = 1'b0;
    end else begin
      if (drain) begin
        wptr_d = (wptr_q == AW'(DEPTH - 1)) ? '0 : AW'(wptr_q + 1'b1);
      end
      if (pop) begin
        rptr_d      = (rptr_q == AW'(DEPTH - 1)) ? '0 : AW'(rptr_q + 1'b1);
        out_d       = mem_q[rptr_q];
        out_valid_d = 1'b1;
      end else if (ld && ren) begin
        out_d        = rd_ofs_sel_q ? WIDTH'(full_ofs_q) : WIDTH'(empty_ofs_q);
        rd_ofs_sel_d = !rd_ofs_sel_q;
      end else if (fall && ren && out_valid_q) begin
        out_valid_d = 1'b0;
      end
      count_d = CW'(count_q + CW'(drain) - CW'(pop));
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_q       <= flagged_fifo_pkg::STANDARD_LATENCY_MODE;
      method_q     <= flagged_fifo_pkg::PROG_SERIAL;
      empty_ofs_q  <= OW'(`FF_OFFSET_DEFAULT_FAR);
      full_ofs_q   <= OW'(`FF_OFFSET_DEFAULT_FAR);
      wr_ofs_sel_q <= 1'b0;
      rd_ofs_sel_q <= 1'b0;
      wptr_q       <= '0;
      rptr_q       <= '0;
      count_q      <= '0;
      out_q        <= '0;
      out_valid_q  <= 1'b0;
    end else begin
      mode_q       <= mode_d;
      method_q     <= method_d;
      empty_ofs_q  <= empty_ofs_d;
      full_ofs_q   <= full_ofs_d;
      wr_ofs_sel_q <= wr_ofs_sel_d;
      rd_ofs_sel_q <= rd_ofs_sel_d;
      wptr_q       <= wptr_d;
      rptr_q       <= rptr_d;
      count_q      <= count_d;
      out_q        <= out_d;
      out_valid_q  <= out_valid_d;
    end
  end

  // The main store has no reset so that it can map onto block memory.
  always_ff @(posedge i_clk_sys) begin
    if (drain) begin
      mem_q[wptr_q] <= skid_data;
    end
  end

  // ==========================================================================
  // Flags
  // In fall-through mode the word waiting in the output stage still counts as held.
  assign level    = CW'(count_q + CW'(fall && out_valid_q));
  assign free_cnt = (level >= CW'(DEPTH)) ? '0 : CW'(CW'(DEPTH) - level);

  assign o_read_data_bus     = out_q;
  assign o_read_data_oe      = !i_output_enable_n;
  assign o_full_or_space_n   = fall ? !in_ready : in_ready;
  assign o_empty_or_valid_n  = fall ? !out_valid_q : !ram_empty;
  assign o_near_full_flag_n  = (free_cnt > CW'(full_ofs_q));
  assign o_near_empty_flag_n = (level > CW'(empty_ofs_q));
  assign o_half_level_flag_n = !(level > CW'(DEPTH / 2));

endmodule

// >>> core/flagged_fifo_cfg.svh
// Configuration constants for the flagged first-in first-out buffer.
`ifndef FLAGGED_FIFO_CFG_SVH
`define FLAGGED_FIFO_CFG_SVH

// ==========================================================================
// Sizes
`define FF_WORD_WIDTH      18
`define FF_DEPTH_SMALL     8192
`define FF_DEPTH_LARGE     16384
`define FF_INGRESS_DEPTH   16

// ==========================================================================
// Default threshold offsets caught at full initialisation reset
`define FF_OFFSET_DEFAULT_NEAR  127
`define FF_OFFSET_DEFAULT_FAR   1023

`endif

// >>> core/flagged_fifo_pkg.sv
// Types shared by the flagged first-in first-out buffer.
package flagged_fifo_pkg;

  typedef enum logic {
    STANDARD_LATENCY_MODE,
    FALL_THROUGH_MODE
  } latency_mode_t;

  typedef enum logic {
    PROG_PARALLEL,
    PROG_SERIAL
  } prog_method_t;

endpackage

// >>> core/ingress_fifo.sv
// Small ingress buffer with valid and ready on both sides.
`timescale 1ns/10ps

module ingress_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 16
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst_n,
  input  wire logic             i_flush,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_q;
  logic [PW-1:0]    wr_d;
  logic [PW-1:0]    rd_q;
  logic [PW-1:0]    rd_d;
  logic [CW-1:0]    cnt_q;
  logic [CW-1:0]    cnt_d;
  logic             push;
  logic             pop;

  assign o_in_ready  = (cnt_q != CW'(DEPTH)) && !i_flush;
  assign o_out_valid = (cnt_q != '0) && !i_flush;
  assign o_out_data  = mem_q[rd_q];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  // ==========================================================================
  // Pointer and count update
  always_comb begin
    wr_d  = wr_q;
    rd_d  = rd_q;
    cnt_d = cnt_q;
    if (i_flush) begin
      wr_d  = '0;
      rd_d  = '0;
      cnt_d = '0;
    end else begin
      if (push) begin
        wr_d = (wr_q == PW'(DEPTH - 1)) ? '0 : PW'(wr_q + 1'b1);
      end
      if (pop) begin
        rd_d = (rd_q == PW'(DEPTH - 1)) ? '0 : PW'(rd_q + 1'b1);
      end
      cnt_d = CW'(cnt_q + CW'(push) - CW'(pop));
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage carries no reset; a word is only read after it was pushed.
  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem_q[wr_q] <= i_in_data;
    end
  end

endmodule

// >>> testbench/fifo_consumer.sv
// Consumer model that pulls words from the buffer whenever i_go is high and it offers them.
`timescale 1ns/10ps
module fifo_consumer (
  input  wire logic i_clk_sys,
  input  wire logic i_rst_n,
  input  wire logic i_go,
  input  wire logic i_empty_or_valid_n,
  output logic      o_read_enable_n
);
  // The strobe follows last cycle's status, so a read may land on an empty store and must be ignored.
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n)
      o_read_enable_n <= 1'b1;
    else
      o_read_enable_n <= !(i_go && i_empty_or_valid_n);
  end
endmodule

// >>> testbench/fifo_port_checker_assertions.sv
// Concurrent checks on the ports of the flagged buffer.
`timescale 1ns/10ps
module fifo_port_checker (
  input wire logic        i_clk_sys,
  input wire logic        i_rst_n,
  input wire logic        i_full_init_reset_n,
  input wire logic        i_pointer_only_reset_n,
  input wire logic        i_replay_request_n,
  input wire logic        i_mode_or_serial_pin,
  input wire logic        i_offset_access_select_n,
  input wire logic        i_write_enable_n,
  input wire logic        i_read_enable_n,
  input wire logic        i_output_enable_n,
  input wire logic [17:0] o_read_data_bus,
  input wire logic        o_read_data_oe,
  input wire logic        o_full_or_space_n,
  input wire logic        o_empty_or_valid_n,
  input wire logic        o_near_full_flag_n,
  input wire logic        o_near_empty_flag_n,
  input wire logic        o_half_level_flag_n
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  logic ft_q, ft_d, quiet, wr_ok;
  // ====
  // Mode tracking
  always_comb begin
    ft_d = i_full_init_reset_n ? ft_q : i_mode_or_serial_pin;
  end
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n)
      ft_q <= 1'b0;
    else
      ft_q <= ft_d;
  end
  assign quiet = i_read_enable_n && i_full_init_reset_n && i_pointer_only_reset_n && i_replay_request_n;
  assign wr_ok = !i_write_enable_n && i_offset_access_select_n && (o_full_or_space_n ^ ft_q);
  // ====
  // Properties
  a_oe_follows_pin: assert property (o_read_data_oe == !i_output_enable_n)
    else $error("read bus drive does not follow output enable");
  a_init_clears_bus: assert property (!i_full_init_reset_n |=> o_read_data_bus == 18'h00000)
    else $error("output register not cleared by full init");
  a_init_levels: assert property (!i_full_init_reset_n |=> !o_near_empty_flag_n && o_half_level_flag_n)
    else $error("level flags wrong after full init");
  a_init_room: assert property (!i_full_init_reset_n |=> o_near_full_flag_n)
    else $error("near full flag wrong after full init");
  a_ptr_clears_bus: assert property (!i_pointer_only_reset_n |=> o_read_data_bus == 18'h00000)
    else $error("output register not cleared by pointer reset");
  a_idle_bus_holds: assert property (!ft_q && quiet |=> $stable(o_read_data_bus))
    else $error("read bus changed without a read");
  a_std_write_shows: assert property (!ft_q && wr_ok && quiet ##1 quiet[*3] |-> ##[0:2] o_empty_or_valid_n)
    else $error("stored word not reported");
  a_ft_word_falls: assert property (ft_q && wr_ok && quiet ##1 quiet[*3] |-> ##[0:2] !o_empty_or_valid_n)
    else $error("first word not presented");
endmodule
bind dual_clock_flagged_fifo fifo_port_checker fifo_port_checker_inst (
  .i_clk_sys, .i_rst_n, .i_full_init_reset_n, .i_pointer_only_reset_n, .i_replay_request_n,
  .i_mode_or_serial_pin, .i_offset_access_select_n, .i_write_enable_n, .i_read_enable_n,
  .i_output_enable_n, .o_read_data_bus, .o_read_data_oe, .o_full_or_space_n, .o_empty_or_valid_n,
  .o_near_full_flag_n, .o_near_empty_flag_n, .o_half_level_flag_n);

// >>> testbench/tb_top.sv
// Self-checking bench for the flagged buffer.
`timescale 1ns/10ps
`include "flagged_fifo_cfg.svh"
module tb_top;
  localparam int DEP = `FF_DEPTH_SMALL;
  localparam int CAP = DEP + `FF_INGRESS_DEPTH;
  logic        clk, rst_n, fi_n, pr_n, rt_n, pin, gate_n, sel_n, wen_n, tren_n, oe_n, go, ft, pend;
  logic        p_ren_n, ren_n, oe, fs_n, ev_n, nf_n, ne_n, hf_n;
  logic [17:0] wd, bus, ex, lw;
  logic [15:0] lf;
  logic [17:0] q[$], all[$];
  int          err_total, checks_done;
  assign ren_n = p_ren_n & tren_n;
  dual_clock_flagged_fifo dual_clock_flagged_fifo_inst (.i_clk_sys(clk), .i_rst_n(rst_n),
    .i_full_init_reset_n(fi_n), .i_pointer_only_reset_n(pr_n), .i_replay_request_n(rt_n),
    .i_mode_or_serial_pin(pin), .i_serial_load_gate_n(gate_n), .i_offset_access_select_n(sel_n),
    .i_write_enable_n(wen_n), .i_write_data_bus(wd), .i_read_enable_n(ren_n), .i_output_enable_n(oe_n),
    .o_read_data_bus(bus), .o_read_data_oe(oe), .o_full_or_space_n(fs_n), .o_empty_or_valid_n(ev_n),
    .o_near_full_flag_n(nf_n), .o_near_empty_flag_n(ne_n), .o_half_level_flag_n(hf_n));
  fifo_consumer fifo_consumer_inst (.i_clk_sys(clk), .i_rst_n(rst_n), .i_go(go),
    .i_empty_or_valid_n(ev_n), .o_read_enable_n(p_ren_n));
  function automatic logic [15:0] nx(input logic [15:0] s);
    nx = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input bit ok);
    checks_done++;
    if (!ok) begin
      err_total++;
      $display("BAD %0t value differs from model", $time);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ====
  // Model of stored words, updated at every rising edge
  always @(posedge clk) begin
    if (pend)
      chk(bus === ex);
    pend = 0;
    if (fi_n && pr_n && rt_n && !ft) begin
      if (!wen_n && sel_n && fs_n) begin
        q.push_back(wd);
        all.push_back(wd);
      end
      if (!ren_n && sel_n && ev_n) begin
        ex = q.pop_front();
        pend = 1;
      end
    end
    if (!rt_n)
      q = all;
    if (!fi_n || !pr_n) begin
      q.delete();
      all.delete();
    end
  end
  // ====
  // Stimulus tasks
  task automatic init(input bit md, s);
    @(posedge clk);
    fi_n <= 1'b0;
    pin <= md;
    sel_n <= s;
    ft = md;
    @(posedge clk);
    fi_n <= 1'b1;
    sel_n <= 1'b1;
    pin <= 1'b0;
  endtask
  task automatic wr(input int k);
    repeat (k) begin
      @(posedge clk);
      lf = nx(lf);
      lw = {lf[1:0], lf};
      wen_n <= 1'b0;
      wd <= lw;
    end
    @(posedge clk);
    wen_n <= 1'b1;
  endtask
  task automatic wo(input int en, em);
    @(posedge clk);
    wen_n <= 1'b0;
    sel_n <= 1'b0;
    wd <= 18'(en);
    @(posedge clk);
    wd <= 18'(em);
    @(posedge clk);
    wen_n <= 1'b1;
    sel_n <= 1'b1;
  endtask
  task automatic rdoff(input int en, em);
    @(posedge clk);
    sel_n <= 1'b0;
    tren_n <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk(bus === 18'(en));
    @(posedge clk);
    sel_n <= 1'b1;
    tren_n <= 1'b1;
    @(negedge clk);
    chk(bus === 18'(em));
  endtask
  // Every second cycle drops the gate and flips the pin, so a leaky gate corrupts the offsets.
  task automatic ser(input int en, em);
    logic [25:0] v;
    v = {13'(em), 13'(en)};
    for (int i = 0; i < 26; i++) begin
      @(posedge clk);
      gate_n <= 1'b0;
      sel_n <= 1'b0;
      pin <= v[i];
      @(posedge clk);
      gate_n <= 1'b1;
      pin <= ~v[i];
    end
    @(posedge clk);
    sel_n <= 1'b1;
  endtask
  task automatic lvl(input int en, em);
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk(ne_n === (q.size() > en));
    chk(nf_n === ((CAP - q.size()) > em));
    chk(hf_n === (q.size() <= DEP / 2));
    chk(ev_n === (q.size() != 0));
    chk(fs_n === (q.size() < CAP));
  endtask
  task automatic pull(input int k);
    @(posedge clk);
    go <= 1'b1;
    repeat (k) @(posedge clk);
    go <= 1'b0;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #600000;
    err_total++;
    tally_and_finish;
  end
  initial begin
    {rst_n, fi_n, pr_n, rt_n, pin, gate_n, sel_n, wen_n, tren_n, oe_n, go, ft, pend} = 13'h0EF8;
    wd = 18'h00000;
    lf = 16'h9EC9;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk(bus === 18'h00000 && ev_n === 1'b0 && ne_n === 1'b0 && hf_n === 1'b1);
    init(1'b0, 1'b0);
    rdoff(127, 127);
    wo(3, 5);
    rdoff(3, 5);
    wr(3);
    lvl(3, 5);
    wr(1);
    lvl(3, 5);
    pull(12);
    @(posedge clk) rt_n <= 1'b0;
    @(posedge clk) rt_n <= 1'b1;
    pull(12);
    lvl(3, 5);
    wr(2);
    @(posedge clk) pr_n <= 1'b0;
    @(posedge clk) pr_n <= 1'b1;
    lvl(3, 5);
    chk(bus === 18'h00000);
    rdoff(3, 5);
    @(posedge clk) oe_n <= 1'b0;
    @(negedge clk) chk(oe === 1'b1);
    @(posedge clk) oe_n <= 1'b1;
    @(negedge clk) chk(oe === 1'b0);
    wr(CAP + 4);
    lvl(3, 5);
    for (int i = 0; i < 30000 && q.size() > 0; i++) begin
      @(posedge clk);
      lf = nx(lf);
      go <= lf[0];
    end
    go <= 1'b0;
    lvl(3, 5);
    init(1'b0, 1'b1);
    rdoff(1023, 1023);
    ser(2, 4);
    rdoff(2, 4);
    init(1'b1, 1'b0);
    wr(1);
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk(bus === lw && ev_n === 1'b0 && fs_n === 1'b0);
    tally_and_finish;
  end
endmodule
